// ---- common/mgr_map.svh ----
// Register map, field positions, reset values and timing counts of the MAC gap/retry block.
// Assumes APB with 32-bit data; each writable register has clear, set and invert aliases above it.
`ifndef MGR_MAP_SVH
`define MGR_MAP_SVH

// ==========================================================
// Register base offsets (each register spans four words)
`define MGR_OFS_DUPLEX       12'h000
`define MGR_OFS_B2B_GAP      12'h010
`define MGR_OFS_NB2B_GAP     12'h020
`define MGR_OFS_SLOT_RETRY   12'h030
`define MGR_OFS_FRAME_LEN    12'h040
`define MGR_OFS_REDUCED      12'h050
`define MGR_OFS_STATUS       12'h060

// ==========================================================
// Alias offsets within a register's group
`define MGR_ALIAS_PLAIN      2'h0
`define MGR_ALIAS_CLEAR      2'h1
`define MGR_ALIAS_SET        2'h2
`define MGR_ALIAS_INVERT     2'h3

// ==========================================================
// Implemented-bit masks
`define MGR_MASK_DUPLEX      32'h0000_0001
`define MGR_MASK_B2B_GAP     32'h0000_007f
`define MGR_MASK_NB2B_GAP    32'h0000_7f7f
`define MGR_MASK_SLOT_RETRY  32'h0000_3f0f
`define MGR_MASK_FRAME_LEN   32'h0000_ffff
`define MGR_MASK_REDUCED     32'h0000_0900

// ==========================================================
// Reset values
`define MGR_RST_DUPLEX       32'h0000_0000
`define MGR_RST_B2B_GAP      32'h0000_0012
`define MGR_RST_NB2B_GAP     32'h0000_0c12
`define MGR_RST_SLOT_RETRY   32'h0000_370f
`define MGR_RST_FRAME_LEN    32'h0000_05ee
`define MGR_RST_REDUCED      32'h0000_1000
// Read-only bits that always read one, whatever was written
`define MGR_RO_REDUCED       32'h0000_1000

// ==========================================================
// Field positions
`define MGR_DEFER_LSB        8
`define MGR_IDLE_LSB         0
`define MGR_SLOT_LSB         8
`define MGR_RETRY_LSB        0
`define MGR_RLRESET_BIT      11
`define MGR_RLSPEED_BIT      8

// ==========================================================
// Timing: nibble period at each line rate, in ns
`define MGR_NIBBLE_100_NS    40
`define MGR_NIBBLE_10_NS     400
`define MGR_CLK_NS           8
`define MGR_NIBBLE_100_CYC   (`MGR_NIBBLE_100_NS / `MGR_CLK_NS)
`define MGR_NIBBLE_10_CYC    (`MGR_NIBBLE_10_NS / `MGR_CLK_NS)
`define MGR_B2B_FD_ADD       3
`define MGR_B2B_HD_ADD       6
`define MGR_BYTE_NIBBLES     2

`endif

// ---- common/mgr_pkg.sv ----
// Types shared by the MAC gap/retry block.
// Assumes the map header carries every number.
package mgr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DEFER  = 3'b001,
		ST_IDLE2  = 3'b010,
		ST_XMIT   = 3'b011,
		ST_BACKIN = 3'b100
	} mgr_gap_st_t;
endpackage

// ---- common/mgr_tick_if.sv ----
// Carrier of the nibble tick between the main block and its tick generator.
// Assumes one clock domain.
`timescale 1ns/100ps
interface mgr_tick_if;
	logic speed_100;
	logic rl_hold;
	logic tick;
	modport gen (input speed_100, input rl_hold, output tick);
	modport use_side (output speed_100, output rl_hold, input tick);
endinterface

// ---- src/mgr_nibble_tick.sv ----
// Nibble-period tick generator for the gap timers.
// Assumes MCLK at 125 MHz; speed and reduced-link hold come from the main block.
`timescale 1ns/100ps
`include "mgr_map.svh"
module mgr_nibble_tick (
	input  wire logic MCLK,
	input  wire logic RST,
	mgr_tick_if.gen   tk
);
	localparam logic [5:0] CYC_100 = 6'(`MGR_NIBBLE_100_CYC - 1);
	localparam logic [5:0] CYC_10  = 6'(`MGR_NIBBLE_10_CYC - 1);
	logic [5:0] cnt_ff;
	logic       tick_ff;
	// ==========================================================
	// Divider; held at zero while the reduced link is in reset
	always_ff @(posedge MCLK) begin
		if (RST || tk.rl_hold) begin
			cnt_ff  <= 6'h0;
			tick_ff <= 1'b0;
		end else if (cnt_ff >= (tk.speed_100 ? CYC_100 : CYC_10)) begin
			cnt_ff  <= 6'h0;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + 6'h1;
			tick_ff <= 1'b0;
		end
	end
	assign tk.tick = tick_ff;

	// ==========================================================
	// Checks
	tick_gap_a: assert property (@(posedge MCLK) disable iff (RST)
		tick_ff && !tk.rl_hold && tk.speed_100 |=> !tick_ff [*4])
		else $error("nibble tick too frequent at 100 Mbps");
	tick_hold_a: assert property (@(posedge MCLK) disable iff (RST)
		tk.rl_hold |=> !tick_ff)
		else $error("tick ran during reduced link reset");
endmodule

// ---- src/mgr_gap_retry.sv ----
// MAC gap, deference, slot window, retry and frame length control with APB registers.
// Assumes APB master on MCLK; CRS_PIN and COL_PIN come from the PHY, others on MCLK.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "mgr_map.svh"
module mgr_gap_retry (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        RMII_MODE,
	input  wire logic        CRS_PIN,
	input  wire logic        COL_PIN,
	input  wire logic        TX_REQ,
	input  wire logic        TX_DONE,
	input  wire logic        RX_END,
	input  wire logic [15:0] RX_LEN,
	output logic             TX_GO,
	output logic             TX_ABORT,
	output logic             SLOT_OPEN,
	output logic             RX_TOO_LONG,
	output logic             RL_RESET,
	output logic             RL_SPEED_100,
	output logic             FULL_DUPLEX
);
	// ==========================================================
	// Registers
	logic [31:0] duplex_ff;
	logic [31:0] b2b_gap_ff;
	logic [31:0] nb2b_gap_ff;
	logic [31:0] slot_retry_ff;
	logic [31:0] frame_len_ff;
	logic [31:0] reduced_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        crs_s1_ff;
	logic        crs_ff;
	logic        col_s1_ff;
	logic        col_ff;
	logic        rx_long_ff;
	logic        tx_go_ff;
	logic        tx_abort_ff;
	logic [6:0]  gap_cnt_ff;
	logic [7:0]  slot_cnt_ff;
	logic [4:0]  attempt_ff;
	logic        last_fd_ff;
	mgr_pkg::mgr_gap_st_t st_ff;
	mgr_pkg::mgr_gap_st_t nxt_st;
	mgr_tick_if tk ();

	// Alias update: 0 plain, 1 clear, 2 set, 3 invert, masked to implemented bits
	function automatic logic [31:0] alias_upd(input logic [31:0] cur,
		input logic [31:0] wd, input logic [1:0] kind, input logic [31:0] msk);
		logic [31:0] r;
		r = cur;
		case (kind)
			`MGR_ALIAS_PLAIN:  r = wd & msk;
			`MGR_ALIAS_CLEAR:  r = cur & ~(wd & msk);
			`MGR_ALIAS_SET:    r = cur | (wd & msk);
			`MGR_ALIAS_INVERT: r = cur ^ (wd & msk);
			default:           r = cur;
		endcase
		return r;
	endfunction

	// Halfword merge: only the written lanes change
	function automatic logic [31:0] lane_mix(input logic [31:0] cur,
		input logic [31:0] upd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{16{strb[3]}}, {16{strb[1]}}};
		return (upd & m) | (cur & ~m);
	endfunction

	// ==========================================================
	// APB decode; byte-wide strobes are dropped quietly
	logic        wr_ok;
	logic [1:0]  akind;
	logic [11:0] abase;
	logic        acc;
	assign acc   = PSEL && PENABLE && pready_ff;
	assign akind = PADDR[3:2];
	assign abase = {PADDR[11:4], 4'h0};
	assign wr_ok = acc && PWRITE && (PSTRB == 4'hf || PSTRB == 4'h3 || PSTRB == 4'hc);

	// One wait state: access phase answered on its second cycle
	always_ff @(posedge MCLK) begin
		if (RST) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= PSEL && PENABLE && !pready_ff;
		end
	end
	assign PREADY  = pready_ff;
	assign PSLVERR = 1'b0;

	// Register writes, each register through its aliases
	always_ff @(posedge MCLK) begin
		if (RST) begin
			duplex_ff     <= `MGR_RST_DUPLEX;
			b2b_gap_ff    <= `MGR_RST_B2B_GAP;
			nb2b_gap_ff   <= `MGR_RST_NB2B_GAP;
			slot_retry_ff <= `MGR_RST_SLOT_RETRY;
			frame_len_ff  <= `MGR_RST_FRAME_LEN;
			reduced_ff    <= `MGR_RST_REDUCED;
		end else if (wr_ok) begin
			case (abase)
				`MGR_OFS_DUPLEX: duplex_ff <= lane_mix(duplex_ff,
					alias_upd(duplex_ff, PWDATA, akind, `MGR_MASK_DUPLEX), PSTRB);
				`MGR_OFS_B2B_GAP: b2b_gap_ff <= lane_mix(b2b_gap_ff,
					alias_upd(b2b_gap_ff, PWDATA, akind, `MGR_MASK_B2B_GAP), PSTRB);
				`MGR_OFS_NB2B_GAP: nb2b_gap_ff <= lane_mix(nb2b_gap_ff,
					alias_upd(nb2b_gap_ff, PWDATA, akind, `MGR_MASK_NB2B_GAP), PSTRB);
				`MGR_OFS_SLOT_RETRY: slot_retry_ff <= lane_mix(slot_retry_ff,
					alias_upd(slot_retry_ff, PWDATA, akind, `MGR_MASK_SLOT_RETRY), PSTRB);
				`MGR_OFS_FRAME_LEN: frame_len_ff <= lane_mix(frame_len_ff,
					alias_upd(frame_len_ff, PWDATA, akind, `MGR_MASK_FRAME_LEN), PSTRB);
				`MGR_OFS_REDUCED: reduced_ff <= lane_mix(reduced_ff,
					alias_upd(reduced_ff, PWDATA, akind, `MGR_MASK_REDUCED), PSTRB);
				default: ;
			endcase
		end
	end

	// Read data; aliases return zero, unmapped reads zero
	always_ff @(posedge MCLK) begin
		if (RST) begin
			prdata_ff <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			if (akind != `MGR_ALIAS_PLAIN) begin
				prdata_ff <= 32'h0000_0000;
			end else begin
				case (abase)
					`MGR_OFS_DUPLEX:     prdata_ff <= duplex_ff;
					`MGR_OFS_B2B_GAP:    prdata_ff <= b2b_gap_ff;
					`MGR_OFS_NB2B_GAP:   prdata_ff <= nb2b_gap_ff;
					`MGR_OFS_SLOT_RETRY: prdata_ff <= slot_retry_ff;
					`MGR_OFS_FRAME_LEN:  prdata_ff <= frame_len_ff;
					`MGR_OFS_REDUCED:    prdata_ff <= reduced_ff | `MGR_RO_REDUCED;
					`MGR_OFS_STATUS:     prdata_ff <= {24'h0000_00, rx_long_ff, crs_ff,
						st_ff, attempt_ff[2:0]};
					default:             prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign PRDATA = prdata_ff;

	// ==========================================================
	// PHY pins through two flip-flops before use
	always_ff @(posedge MCLK) begin
		if (RST) begin
			crs_s1_ff <= 1'b0;
			crs_ff    <= 1'b0;
			col_s1_ff <= 1'b0;
			col_ff    <= 1'b0;
		end else begin
			crs_s1_ff <= CRS_PIN;
			crs_ff    <= crs_s1_ff;
			col_s1_ff <= COL_PIN;
			col_ff    <= col_s1_ff;
		end
	end

	// ==========================================================
	// Reduced link control only acts in RMII mode; MII always runs at the 100 Mbps tick
	logic fd;
	assign fd           = duplex_ff[0];
	assign RL_RESET     = RMII_MODE && reduced_ff[`MGR_RLRESET_BIT];
	assign RL_SPEED_100 = RMII_MODE ? reduced_ff[`MGR_RLSPEED_BIT] : 1'b1;
	assign FULL_DUPLEX  = fd;
	assign tk.speed_100 = RL_SPEED_100;
	assign tk.rl_hold   = RL_RESET;

	mgr_nibble_tick u_tick (
		.MCLK (MCLK),
		.RST  (RST),
		.tk   (tk)
	);

	// ==========================================================
	// Gap sequencing
	logic [6:0] defer_part;
	logic [6:0] idle_part;
	logic [6:0] b2b_len;
	logic [5:0] slot_bytes;
	logic [3:0] retry_limit;
	logic       gap_hit;
	assign defer_part  = nb2b_gap_ff[`MGR_DEFER_LSB +: 7];
	assign idle_part   = nb2b_gap_ff[`MGR_IDLE_LSB +: 7];
	assign slot_bytes  = slot_retry_ff[`MGR_SLOT_LSB +: 6];
	assign retry_limit = slot_retry_ff[`MGR_RETRY_LSB +: 4];
	// Desired gap is field plus three or six nibbles; wraps above 127, keep field small
	assign b2b_len = 7'(b2b_gap_ff[6:0] + (fd ? 7'(`MGR_B2B_FD_ADD) : 7'(`MGR_B2B_HD_ADD)));
	assign gap_hit = tk.tick && (gap_cnt_ff != 7'h7f);

	// Next state of the gap machine
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			mgr_pkg::ST_IDLE:   if (TX_REQ && !RL_RESET) nxt_st = mgr_pkg::ST_DEFER;
			mgr_pkg::ST_DEFER: begin
				if (!fd && crs_ff) nxt_st = mgr_pkg::ST_DEFER;
				else if (gap_cnt_ff >= (last_fd_ff ? b2b_len : defer_part))
					nxt_st = mgr_pkg::ST_IDLE2;
			end
			mgr_pkg::ST_IDLE2:  if (last_fd_ff ? 1'b1 : gap_cnt_ff >= idle_part)
				nxt_st = mgr_pkg::ST_XMIT;
			mgr_pkg::ST_XMIT: begin
				if (!fd && col_ff && SLOT_OPEN) nxt_st = mgr_pkg::ST_BACKIN;
				else if (TX_DONE) nxt_st = mgr_pkg::ST_IDLE;
			end
			mgr_pkg::ST_BACKIN: nxt_st = mgr_pkg::ST_IDLE;
			default:            nxt_st = mgr_pkg::ST_IDLE;
		endcase
	end

	// State, gap counter and mode latch; carrier in first part restarts timing in half duplex
	always_ff @(posedge MCLK) begin
		if (RST) begin
			st_ff      <= mgr_pkg::ST_IDLE;
			gap_cnt_ff <= 7'h00;
			last_fd_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (st_ff == mgr_pkg::ST_IDLE) begin
				last_fd_ff <= fd;
			end
			if (nxt_st != st_ff && nxt_st != mgr_pkg::ST_IDLE2) begin
				gap_cnt_ff <= 7'h00;
			end else if (st_ff == mgr_pkg::ST_DEFER && !fd && crs_ff) begin
				gap_cnt_ff <= 7'h00;
			end else if (gap_hit) begin
				gap_cnt_ff <= gap_cnt_ff + 7'h01;
			end
		end
	end

	// Slot window counted in nibble ticks from start of transmission, two per programmed byte
	always_ff @(posedge MCLK) begin
		if (RST || st_ff != mgr_pkg::ST_XMIT) begin
			slot_cnt_ff <= 8'h00;
		end else if (tk.tick && slot_cnt_ff != 8'hff) begin
			slot_cnt_ff <= slot_cnt_ff + 8'h01;
		end
	end
	assign SLOT_OPEN = (st_ff == mgr_pkg::ST_XMIT)
		&& (slot_cnt_ff < {1'b0, slot_bytes, 1'b0});

	// Attempt counter: cleared on TX_DONE or on abort, bumped on each half-duplex collision inside the slot window, below the retry limit
	always_ff @(posedge MCLK) begin
		if (RST) begin
			attempt_ff  <= 5'h00;
			tx_abort_ff <= 1'b0;
			tx_go_ff    <= 1'b0;
		end else begin
			tx_go_ff    <= (nxt_st == mgr_pkg::ST_XMIT) && (st_ff != mgr_pkg::ST_XMIT);
			tx_abort_ff <= 1'b0;
			if (st_ff == mgr_pkg::ST_XMIT && TX_DONE && nxt_st == mgr_pkg::ST_IDLE) begin
				attempt_ff <= 5'h00;
			end else if (st_ff == mgr_pkg::ST_BACKIN) begin
				if (attempt_ff >= {1'b0, retry_limit}) begin
					attempt_ff  <= 5'h00;
					tx_abort_ff <= 1'b1;
				end else begin
					attempt_ff <= attempt_ff + 5'h01;
				end
			end
		end
	end
	assign TX_GO    = tx_go_ff;
	assign TX_ABORT = tx_abort_ff;

	// Receive length check against the programmed limit
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rx_long_ff <= 1'b0;
		end else if (RX_END) begin
			rx_long_ff <= RX_LEN > frame_len_ff[15:0];
		end
	end
	assign RX_TOO_LONG = rx_long_ff;

	// ==========================================================
	// Checks
	alias_clear_a: assert property (@(posedge MCLK) disable iff (RST)
		wr_ok && abase == `MGR_OFS_FRAME_LEN && akind == `MGR_ALIAS_CLEAR && PSTRB == 4'hf
		|=> frame_len_ff == ($past(frame_len_ff) & ~($past(PWDATA) & 32'h0000_ffff)))
		else $error("clear alias failed");
	alias_set_a: assert property (@(posedge MCLK) disable iff (RST)
		wr_ok && abase == `MGR_OFS_FRAME_LEN && akind == `MGR_ALIAS_SET && PSTRB == 4'hf
		|=> frame_len_ff == ($past(frame_len_ff) | ($past(PWDATA) & 32'h0000_ffff)))
		else $error("set alias failed");
	alias_inv_a: assert property (@(posedge MCLK) disable iff (RST)
		wr_ok && abase == `MGR_OFS_FRAME_LEN && akind == `MGR_ALIAS_INVERT && PSTRB == 4'hf
		|=> frame_len_ff == ($past(frame_len_ff) ^ ($past(PWDATA) & 32'h0000_ffff)))
		else $error("invert alias failed");
	byte_ignore_a: assert property (@(posedge MCLK) disable iff (RST)
		acc && PWRITE && (PSTRB == 4'h1 || PSTRB == 4'h2)
		|=> $stable(frame_len_ff) && $stable(nb2b_gap_ff))
		else $error("byte write changed a register");
	defer_carrier_a: assert property (@(posedge MCLK) disable iff (RST)
		st_ff == mgr_pkg::ST_DEFER && !fd && crs_ff |=> st_ff == mgr_pkg::ST_DEFER)
		else $error("left deferral during carrier");
	idle_part_a: assert property (@(posedge MCLK) disable iff (RST)
		st_ff == mgr_pkg::ST_IDLE2 && !last_fd_ff && gap_cnt_ff < idle_part
		|=> st_ff != mgr_pkg::ST_XMIT)
		else $error("transmitted before second gap part");
	retry_abort_a: assert property (@(posedge MCLK) disable iff (RST)
		st_ff == mgr_pkg::ST_BACKIN && attempt_ff < {1'b0, retry_limit}
		|=> !tx_abort_ff && attempt_ff == $past(attempt_ff) + 5'h01)
		else $error("attempt count wrong");
	rl_mii_a: assert property (@(posedge MCLK) disable iff (RST)
		!RMII_MODE |-> !RL_RESET && RL_SPEED_100)
		else $error("reduced link bits leak into MII");
	len_check_a: assert property (@(posedge MCLK) disable iff (RST)
		RX_END && RX_LEN > frame_len_ff[15:0] |=> rx_long_ff)
		else $error("long frame not flagged");
	apb_ready_a: assert property (@(posedge MCLK) disable iff (RST)
		PSEL && !PENABLE ##1 PSEL && PENABLE |-> !pready_ff ##1 pready_ff)
		else $error("APB answer timing wrong");
	cov_defer_c: cover property (@(posedge MCLK) disable iff (RST)
		st_ff == mgr_pkg::ST_DEFER && crs_ff);
	cov_abort_c: cover property (@(posedge MCLK) disable iff (RST) tx_abort_ff);
	cov_go_c: cover property (@(posedge MCLK) disable iff (RST) tx_go_ff);
	cov_long_c: cover property (@(posedge MCLK) disable iff (RST) rx_long_ff);
endmodule

// ---- test/mgr_phy_model.sv ----
// Behavioural PHY on the far side of the gap/retry block: carrier and collision pins.
// Assumes one MCLK domain; both pins idle low between events, as a PHY drives them.
`timescale 1ns/100ps
module mgr_phy_model (
	input  wire logic mclk,
	input  wire logic tx_go,
	output logic      crs,
	output logic      col
);
	int col_left_ff;
	int col_cnt_ff;

	// ==========================================================
	// Controls
	// Quiet pins at start so the block never sees a floating level
	initial begin
		crs = 1'b0;
		col = 1'b0;
		col_left_ff = 0;
		col_cnt_ff = 0;
	end

	// Carrier burst after a delay, in MCLK cycles
	task automatic carrier(input int dly, input int len);
		repeat (dly) @(posedge mclk);
		crs <= 1'b1;
		repeat (len) @(posedge mclk);
		crs <= 1'b0;
	endtask

	// Number of coming attempts that will collide
	task automatic collisions(input int n);
		col_left_ff = n;
	endtask

	// ==========================================================
	// Collision response
	// Jam lands early in the slot so a half-duplex sender must back off
	always @(posedge mclk) begin
		if (tx_go === 1'b1 && col_left_ff > 0) begin
			col_left_ff <= col_left_ff - 1;
			col_cnt_ff <= 6;
		end else if (col_cnt_ff > 0) begin
			col_cnt_ff <= col_cnt_ff - 1;
		end
		col <= (col_cnt_ff >= 1 && col_cnt_ff <= 4);
	end
endmodule

// ---- test/tb_mgr_gap_retry.sv ----
// Self-checking bench of the MAC gap/retry block: APB registers, gaps, retries, length.
// Assumes the map header for offsets and masks, reset values written out here; PHY model on the carrier pins.
`timescale 1ns/100ps
`include "mgr_map.svh"
module tb_mgr_gap_retry;
	logic        MCLK, RST, PSEL, PENABLE, PWRITE, RMII_MODE, TX_REQ, TX_DONE, RX_END;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, rd, ex, v;
	logic [3:0]  PSTRB;
	logic [15:0] RX_LEN;
	wire  logic [31:0] PRDATA;
	wire  logic        PREADY, PSLVERR, CRS_PIN, COL_PIN, TX_GO, TX_ABORT, SLOT_OPEN;
	wire  logic        RX_TOO_LONG, RL_RESET, RL_SPEED_100, FULL_DUPLEX;
	int          err_count, n_checks, cycles, seed, gos, base, c, ab;
	logic [11:0] ofs [6];
	logic [31:0] msk [6];
	logic [31:0] rstv [6];

	mgr_gap_retry u_mgr_gap_retry (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .RMII_MODE(RMII_MODE), .CRS_PIN(CRS_PIN),
		.COL_PIN(COL_PIN), .TX_REQ(TX_REQ), .TX_DONE(TX_DONE), .RX_END(RX_END),
		.RX_LEN(RX_LEN), .TX_GO(TX_GO), .TX_ABORT(TX_ABORT), .SLOT_OPEN(SLOT_OPEN),
		.RX_TOO_LONG(RX_TOO_LONG), .RL_RESET(RL_RESET), .RL_SPEED_100(RL_SPEED_100),
		.FULL_DUPLEX(FULL_DUPLEX));
	mgr_phy_model u_mgr_phy_model (.mclk(MCLK), .tx_go(TX_GO), .crs(CRS_PIN), .col(COL_PIN));

	// ==========================================================
	// Clock and cycle ceiling
	initial MCLK = 1'b0;
	always #4 MCLK = ~MCLK;
	// A hung wait counts as a mismatch and closes the run
	always @(posedge MCLK) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			err_count++;
			final_report();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic final_report();
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h, expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until PREADY is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= s;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge MCLK);
		end while (PREADY !== 1'b1);
		r = PRDATA;
		check({31'h0, PSLVERR}, 32'h0000_0000);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		apb(1'b1, a, d, s, r);
		// Register lands on the answer edge; look at outputs only after it
		@(negedge MCLK);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, 4'hf, r);
		check(r, e);
	endtask

	// Bit 12 of the reduced-link register always reads one
	function automatic logic [31:0] view(input int i, input logic [31:0] x);
		return (i == 5) ? (x | 32'h0000_1000) : x;
	endfunction

	task automatic rx(input logic [15:0] len, input logic e);
		@(posedge MCLK);
		RX_LEN <= len;
		RX_END <= 1'b1;
		@(posedge MCLK);
		RX_END <= 1'b0;
		@(negedge MCLK);
		check({31'h0, RX_TOO_LONG}, {31'h0, e});
	endtask

	// Cycles from request to TX_GO, then a clean end of transmission
	task automatic measure(input bit sl, output int cyc);
		cyc = 0;
		@(posedge MCLK);
		TX_REQ <= 1'b1;
		do begin
			@(negedge MCLK);
			cyc++;
		end while (TX_GO !== 1'b1 && cyc < 3000);
		@(posedge MCLK);
		TX_REQ <= 1'b0;
		repeat (2) @(negedge MCLK);
		if (sl) check({31'h0, SLOT_OPEN}, 32'h0000_0001);
		repeat (40) @(negedge MCLK);
		if (sl) check({31'h0, SLOT_OPEN}, 32'h0000_0000);
		@(posedge MCLK);
		TX_DONE <= 1'b1;
		@(posedge MCLK);
		TX_DONE <= 1'b0;
		repeat (4) @(posedge MCLK);
	endtask

	// Packet with ncol collisions; ends on abort or on the first clean attempt
	task automatic run_pkt(input int ncol);
		int n;
		gos = 0;
		ab = 0;
		u_mgr_phy_model.collisions(ncol);
		@(posedge MCLK);
		TX_REQ <= 1'b1;
		for (n = 0; n < 4000 && ab == 0 && gos <= ncol; n++) begin
			@(negedge MCLK);
			if (TX_GO === 1'b1) gos++;
			if (TX_ABORT === 1'b1) ab = 1;
		end
		u_mgr_phy_model.collisions(0);
		@(posedge MCLK);
		TX_REQ <= 1'b0;
		repeat (150) @(posedge MCLK);
		TX_DONE <= 1'b1;
		@(posedge MCLK);
		TX_DONE <= 1'b0;
		repeat (20) @(posedge MCLK);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{RST, PSEL, PENABLE, PWRITE, TX_REQ, TX_DONE, RX_END} = 7'b100_0000;
		RMII_MODE = 1'b1;
		PADDR = 12'h000;
		PWDATA = 32'h0000_0000;
		PSTRB = 4'h0;
		RX_LEN = 16'h0000;
		{err_count, n_checks, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd74};
		ofs = '{`MGR_OFS_DUPLEX, `MGR_OFS_B2B_GAP, `MGR_OFS_NB2B_GAP, `MGR_OFS_SLOT_RETRY,
			`MGR_OFS_FRAME_LEN, `MGR_OFS_REDUCED};
		msk = '{`MGR_MASK_DUPLEX, `MGR_MASK_B2B_GAP, `MGR_MASK_NB2B_GAP,
			`MGR_MASK_SLOT_RETRY, `MGR_MASK_FRAME_LEN, `MGR_MASK_REDUCED};
		rstv = '{32'h0000_0000, 32'h0000_0012, 32'h0000_0c12, 32'h0000_370f,
			32'h0000_05ee, 32'h0000_1000};
		repeat (16) @(posedge MCLK);
		RST <= 1'b0;
		// Reset values, then random plain writes and each alias kind
		for (int i = 0; i < 6; i++) begin
			rdc(ofs[i], rstv[i]);
			v = $random(seed) & msk[i];
			wr(ofs[i], v, 4'hf);
			ex = v & msk[i];
			for (int k = 1; k < 4; k++) begin
				v = $random(seed) & msk[i];
				wr(ofs[i] + 12'(4 * k), v, 4'hf);
				ex = (k == 1) ? (ex & ~v) : (k == 2) ? (ex | (v & msk[i])) : (ex ^ (v & msk[i]));
				rdc(ofs[i], view(i, ex));
				rdc(ofs[i] + 12'(4 * k), 32'h0000_0000);
			end
		end
		rdc(12'h070, 32'h0000_0000);
		// Byte lanes refused, halfwords taken
		wr(`MGR_OFS_FRAME_LEN, 32'h0000_05ee, 4'hf);
		for (int k = 0; k < 4; k++) wr(`MGR_OFS_FRAME_LEN + 12'h008, 32'hffff_ffff, 4'(1 << k));
		wr(`MGR_OFS_FRAME_LEN, 32'hffff_0000, 4'b1100);
		rdc(`MGR_OFS_FRAME_LEN, 32'h0000_05ee);
		wr(`MGR_OFS_FRAME_LEN, 32'h1234_05f2, 4'b0011);
		rdc(`MGR_OFS_FRAME_LEN, 32'h0000_05f2);
		// Length ceiling at 1518, then tagged and headed frames
		wr(`MGR_OFS_FRAME_LEN, 32'h0000_05ee, 4'hf);
		rx(16'd1518, 1'b0);
		rx(16'd1519, 1'b1);
		wr(`MGR_OFS_FRAME_LEN, 32'h0000_05f2, 4'hf);
		rx(16'd1522, 1'b0);
		rx(16'd1523, 1'b1);
		wr(`MGR_OFS_FRAME_LEN, 32'h0000_05f7, 4'hf);
		rx(16'd1527, 1'b0);
		// Half duplex, RMII at 100, deference 4, idle 6, slot 2 bytes, retry 2
		wr(`MGR_OFS_DUPLEX, 32'h0000_0000, 4'hf);
		wr(`MGR_OFS_REDUCED, 32'h0000_0100, 4'hf);
		wr(`MGR_OFS_NB2B_GAP, 32'h0000_0406, 4'hf);
		wr(`MGR_OFS_SLOT_RETRY, 32'h0000_0202, 4'hf);
		check({31'h0, RL_SPEED_100}, 32'h0000_0001);
		check({31'h0, FULL_DUPLEX}, 32'h0000_0000);
		measure(1'b1, base);
		// Six idle ticks of five cycles, plus request, sync and tick phase
		check({31'h0, base >= 6 * `MGR_NIBBLE_100_CYC - 1
			&& base <= 6 * `MGR_NIBBLE_100_CYC + 5}, 32'h0000_0001);
		// Carrier inside the deference part pushes the start out
		fork
			measure(1'b1, c);
			u_mgr_phy_model.carrier(3, 60);
		join
		check({31'h0, c >= base + 50}, 32'h0000_0001);
		// Carrier after the deference part is ignored
		fork
			measure(1'b1, c);
			u_mgr_phy_model.carrier(23, 60);
		join
		check({31'h0, c <= base + 8}, 32'h0000_0001);
		// Ten times slower nibble rate at 10 Mbps
		wr(`MGR_OFS_REDUCED, 32'h0000_0000, 4'hf);
		check({31'h0, RL_SPEED_100}, 32'h0000_0000);
		measure(1'b0, c);
		check({31'h0, c >= 8 * base && c <= 12 * base}, 32'h0000_0001);
		wr(`MGR_OFS_REDUCED, 32'h0000_0100, 4'hf);
		// Excessive collisions abort; the next packet starts a fresh count
		run_pkt(10);
		check({31'h0, ab == 1 && gos == 3}, 32'h0000_0001);
		run_pkt(1);
		check({31'h0, ab == 0 && gos == 2}, 32'h0000_0001);
		// Reduced-link reset holds off transmission
		wr(`MGR_OFS_REDUCED, 32'h0000_0900, 4'hf);
		check({31'h0, RL_RESET}, 32'h0000_0001);
		@(posedge MCLK);
		TX_REQ <= 1'b1;
		gos = 0;
		repeat (200) begin
			@(negedge MCLK);
			if (TX_GO === 1'b1) gos++;
		end
		check(32'(gos), 32'h0000_0000);
		@(posedge MCLK);
		TX_REQ <= 1'b0;
		wr(`MGR_OFS_REDUCED, 32'h0000_0000, 4'hf);
		check({31'h0, RL_RESET}, 32'h0000_0000);
		// MII path ignores the reduced-link speed bit
		@(posedge MCLK);
		RMII_MODE <= 1'b0;
		@(negedge MCLK);
		check({31'h0, RL_SPEED_100}, 32'h0000_0001);
		// Full duplex uses the consecutive gap plus three nibbles
		wr(`MGR_OFS_B2B_GAP, 32'h0000_0012, 4'hf);
		wr(`MGR_OFS_DUPLEX, 32'h0000_0001, 4'hf);
		check({31'h0, FULL_DUPLEX}, 32'h0000_0001);
		measure(1'b0, c);
		check({31'h0, c >= 100 && c <= 125}, 32'h0000_0001);
		final_report();
	end
endmodule
